// file: srst_consts.svh
// Offsets, field positions, masks and reset values of the soft reset block
`ifndef SRST_CONSTS_SVH
`define SRST_CONSTS_SVH

// Byte addresses of the two control words
`define SRST_OFF_0        12'h040
`define SRST_OFF_1        12'h044

// Reset value of both control words
`define SRST_RESET_VAL    32'h0000_0000

// Implemented bits of the first control word
`define SRST_BIT_FIELD_BUS   24
`define SRST_BIT_CONVERTER   16
`define SRST_BIT_LOW_POWER   6
`define SRST_BIT_SUPERVISOR  3
`define SRST_IMPL_0       32'h0101_0048

// Implemented bits of the second control word
`define SRST_BIT_CMP_TWO     26
`define SRST_BIT_CMP_ONE     25
`define SRST_BIT_CMP_ZERO    24
`define SRST_BIT_GPC_THREE   19
`define SRST_BIT_GPC_TWO     18
`define SRST_BIT_GPC_ONE     17
`define SRST_BIT_GPC_ZERO    16
`define SRST_BIT_TWO_WIRE    12
`define SRST_BIT_SYNC_SER    4
`define SRST_BIT_ASYNC_ONE   1
`define SRST_BIT_ASYNC_ZERO  0
`define SRST_IMPL_1       32'h070f_1013

// Bus answers
`define SRST_RESP_OKAY    2'h0
`define SRST_RESP_SLVERR  2'h2
`define SRST_RDATA_NONE   32'h0000_0000

`endif

// file: srst_pkg.sv
// Types shared by the soft reset block modules
package srst_pkg;

    typedef logic [31:0] srst_word_t;
    typedef logic [11:0] srst_addr_t;
    typedef logic [3:0]  srst_strb_t;
    typedef logic [1:0]  srst_resp_t;

    typedef enum logic [0:0] {
        srst_w_idle = 1'b0,
        srst_w_resp = 1'b1
    } srst_wr_state_t;

    typedef enum logic [0:0] {
        srst_r_idle = 1'b0,
        srst_r_data = 1'b1
    } srst_rd_state_t;

    typedef struct packed {
        srst_wr_state_t wst;
        logic           aw_held;
        logic           w_held;
        srst_addr_t     awaddr;
        srst_word_t     wdata;
        srst_strb_t     wstrb;
        srst_resp_t     bresp;
        srst_rd_state_t rd_st;
        srst_word_t     rdata;
        srst_resp_t     rresp;
    } srst_top_state_t;

    typedef struct packed {
        srst_word_t value;
    } srst_reg_state_t;

    typedef struct packed {
        srst_word_t hold0;
        srst_word_t hold1;
    } srst_hold_state_t;

endpackage

// file: srst_ctl_if.sv
// Write path and read-back between the bus slave and one control word
`timescale 1ns/1ps
`default_nettype none

interface srst_ctl_if;
    logic        wr_en;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [31:0] cap;
    logic [31:0] value;

    modport ctl
    (
        output wr_en,
        output wr_data,
        output wr_strb,
        output cap,
        input  value
    );

    modport regs
    (
        input  wr_en,
        input  wr_data,
        input  wr_strb,
        input  cap,
        output value
    );
endinterface

`default_nettype wire

// file: srst_mask_reg.sv
// One capability-masked soft reset control word
`timescale 1ns/1ps
`default_nettype none
`include "srst_consts.svh"

module srst_mask_reg
#(
    parameter logic [31:0] IMPL = 32'h0000_0000
)
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  reset,
    // Register port
    srst_ctl_if.regs   bus
);
    import srst_pkg::*;

    srst_reg_state_t s_r;
    srst_reg_state_t s_nxt;
    srst_word_t      en;

    always_comb
    begin
        s_nxt = s_r;
        en = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            en[i*8 +: 8] = {8{bus.wr_en & bus.wr_strb[i]}};
        end
        // Absent units and unassigned bits never change
        en = en & bus.cap & IMPL;
        s_nxt.value = (s_r.value & ~en) | (bus.wr_data & en);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_r.value <= `SRST_RESET_VAL;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus.value = s_r.value & IMPL;

endmodule

`default_nettype wire

// file: srst_hold_out.sv
// Registered reset-hold stage for the peripheral units
`timescale 1ns/1ps
`default_nettype none
`include "srst_consts.svh"

module srst_hold_out
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Control words
    input  wire srst_pkg::srst_word_t value0,
    input  wire srst_pkg::srst_word_t value1,
    // Hold levels
    output var  srst_pkg::srst_word_t hold0,
    output var  srst_pkg::srst_word_t hold1
);
    import srst_pkg::*;

    srst_hold_state_t s_r;
    srst_hold_state_t s_nxt;

    // Flop stage keeps the reset lines glitch free across the chip
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.hold0 = value0 & `SRST_IMPL_0;
        s_nxt.hold1 = value1 & `SRST_IMPL_1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign hold0 = s_r.hold0;
    assign hold1 = s_r.hold1;

endmodule

`default_nettype wire

// file: srst_top.sv
// Peripheral soft reset control words behind an AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "srst_consts.svh"

module srst_top
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // AXI4-Lite write address
    input  wire srst_pkg::srst_addr_t s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output var  logic                 s_axi_awready,
    // AXI4-Lite write data
    input  wire srst_pkg::srst_word_t s_axi_wdata,
    input  wire srst_pkg::srst_strb_t s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output var  logic                 s_axi_wready,
    // AXI4-Lite write response
    output var  srst_pkg::srst_resp_t s_axi_bresp,
    output var  logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire srst_pkg::srst_addr_t s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output var  logic                 s_axi_arready,
    // AXI4-Lite read data
    output var  srst_pkg::srst_word_t s_axi_rdata,
    output var  srst_pkg::srst_resp_t s_axi_rresp,
    output var  logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Device capability masks
    input  wire srst_pkg::srst_word_t capability_mask_1,
    input  wire srst_pkg::srst_word_t capability_mask_2,
    // Unit resets from word 0
    output var  logic                 field_bus_unit_reset,
    output var  logic                 sampling_converter_reset,
    output var  logic                 low_power_unit_reset,
    output var  logic                 supervisor_timer_reset,
    // Unit resets from word 1
    output var  logic                 comparator_two_reset,
    output var  logic                 comparator_one_reset,
    output var  logic                 comparator_zero_reset,
    output var  logic                 gp_counter_three_reset,
    output var  logic                 gp_counter_two_reset,
    output var  logic                 gp_counter_one_reset,
    output var  logic                 gp_counter_zero_reset,
    output var  logic                 two_wire_unit_reset,
    output var  logic                 sync_serial_unit_reset,
    output var  logic                 async_serial_one_reset,
    output var  logic                 async_serial_zero_reset
);
    import srst_pkg::*;

    srst_top_state_t s_r;
    srst_top_state_t s_nxt;

    logic       commit;
    logic       wr_hit0;
    logic       wr_hit1;
    logic       rd_hit0;
    logic       rd_hit1;
    srst_word_t hold0;
    srst_word_t hold1;
    logic       prot_unused;

    // One carrier per control word
    srst_ctl_if ctl0 ();
    srst_ctl_if ctl1 ();

    // Protection bits carry no meaning for these words
    assign prot_unused = |{s_axi_awprot, s_axi_arprot};

    // Write decode works on the captured address
    always_comb
    begin
        wr_hit0 = 1'b0;
        wr_hit1 = 1'b0;
        rd_hit0 = 1'b0;
        rd_hit1 = 1'b0;
        case ({s_r.awaddr[11:2], 2'b00})
            `SRST_OFF_0:
            begin
                wr_hit0 = 1'b1;
            end
            `SRST_OFF_1:
            begin
                wr_hit1 = 1'b1;
            end
            default:
            begin
                wr_hit0 = 1'b0;
                wr_hit1 = 1'b0;
            end
        endcase

        // Read decode uses the live address of the idle cycle
        case ({s_axi_araddr[11:2], 2'b00})
            `SRST_OFF_0:
            begin
                rd_hit0 = 1'b1;
            end
            `SRST_OFF_1:
            begin
                rd_hit1 = 1'b1;
            end
            default:
            begin
                rd_hit0 = 1'b0;
                rd_hit1 = 1'b0;
            end
        endcase
    end

    // Both halves of a write are in hand; apply it this cycle
    assign commit = (s_r.wst == srst_w_idle) && s_r.aw_held && s_r.w_held;

    always_comb
    begin
        s_nxt = s_r;

        // Address and data may arrive in either order
        case (s_r.wst)
            srst_w_idle:
            begin
                if (s_axi_awvalid && !s_r.aw_held)
                begin
                    s_nxt.aw_held = 1'b1;
                    s_nxt.awaddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && !s_r.w_held)
                begin
                    s_nxt.w_held = 1'b1;
                    s_nxt.wdata = s_axi_wdata;
                    s_nxt.wstrb = s_axi_wstrb;
                end
                if (commit)
                begin
                    s_nxt.aw_held = 1'b0;
                    s_nxt.w_held = 1'b0;
                    s_nxt.wst = srst_w_resp;
                    if (wr_hit0 || wr_hit1)
                    begin
                        s_nxt.bresp = `SRST_RESP_OKAY;
                    end
                    else
                    begin
                        s_nxt.bresp = `SRST_RESP_SLVERR;
                    end
                end
            end
            srst_w_resp:
            begin
                if (s_axi_bready)
                begin
                    s_nxt.wst = srst_w_idle;
                end
            end
            default:
            begin
                s_nxt.wst = srst_w_idle;
            end
        endcase

        // Reads overlap writes; a read in the commit cycle sees the old word
        case (s_r.rd_st)
            srst_r_idle:
            begin
                if (s_axi_arvalid)
                begin
                    s_nxt.rd_st = srst_r_data;
                    s_nxt.rresp = `SRST_RESP_OKAY;
                    if (rd_hit0)
                    begin
                        s_nxt.rdata = ctl0.value;
                    end
                    else if (rd_hit1)
                    begin
                        s_nxt.rdata = ctl1.value;
                    end
                    else
                    begin
                        // Unmapped reads return zero with an error
                        s_nxt.rdata = `SRST_RDATA_NONE;
                        s_nxt.rresp = `SRST_RESP_SLVERR;
                    end
                end
            end
            srst_r_data:
            begin
                if (s_axi_rready)
                begin
                    s_nxt.rd_st = srst_r_idle;
                end
            end
            default:
            begin
                s_nxt.rd_st = srst_r_idle;
            end
        endcase
    end

    // Bus state clears with the words so no stale answer survives reset
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Handshake outputs
    assign s_axi_awready = (s_r.wst == srst_w_idle) && !s_r.aw_held;
    assign s_axi_wready  = (s_r.wst == srst_w_idle) && !s_r.w_held;
    assign s_axi_bvalid  = (s_r.wst == srst_w_resp);
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = (s_r.rd_st == srst_r_idle);
    assign s_axi_rvalid  = (s_r.rd_st == srst_r_data);
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

    // Write strobes toward the two words
    assign ctl0.wr_en   = commit && wr_hit0;
    assign ctl0.wr_data = s_r.wdata;
    assign ctl0.wr_strb = s_r.wstrb;
    assign ctl0.cap     = capability_mask_1;
    assign ctl1.wr_en   = commit && wr_hit1;
    assign ctl1.wr_data = s_r.wdata;
    assign ctl1.wr_strb = s_r.wstrb;
    assign ctl1.cap     = capability_mask_2;

    srst_mask_reg #(
        .IMPL (`SRST_IMPL_0)
    ) u_word0 (
        .clk   (clk),
        .reset (reset),
        .bus   (ctl0)
    );

    srst_mask_reg #(
        .IMPL (`SRST_IMPL_1)
    ) u_word1 (
        .clk   (clk),
        .reset (reset),
        .bus   (ctl1)
    );

    // One cycle later than the word, so a unit never sees a half write
    srst_hold_out u_hold (
        .clk    (clk),
        .reset  (reset),
        .value0 (ctl0.value),
        .value1 (ctl1.value),
        .hold0  (hold0),
        .hold1  (hold1)
    );

    // Word 0 unit resets
    assign field_bus_unit_reset     = hold0[`SRST_BIT_FIELD_BUS];
    assign sampling_converter_reset = hold0[`SRST_BIT_CONVERTER];
    assign low_power_unit_reset     = hold0[`SRST_BIT_LOW_POWER];
    assign supervisor_timer_reset   = hold0[`SRST_BIT_SUPERVISOR];

    // Word 1 unit resets
    assign comparator_two_reset     = hold1[`SRST_BIT_CMP_TWO];
    assign comparator_one_reset     = hold1[`SRST_BIT_CMP_ONE];
    assign comparator_zero_reset    = hold1[`SRST_BIT_CMP_ZERO];
    assign gp_counter_three_reset   = hold1[`SRST_BIT_GPC_THREE];
    assign gp_counter_two_reset     = hold1[`SRST_BIT_GPC_TWO];
    assign gp_counter_one_reset     = hold1[`SRST_BIT_GPC_ONE];
    assign gp_counter_zero_reset    = hold1[`SRST_BIT_GPC_ZERO];
    assign two_wire_unit_reset      = hold1[`SRST_BIT_TWO_WIRE];
    assign sync_serial_unit_reset   = hold1[`SRST_BIT_SYNC_SER];
    assign async_serial_one_reset   = hold1[`SRST_BIT_ASYNC_ONE];
    assign async_serial_zero_reset  = hold1[`SRST_BIT_ASYNC_ZERO];

endmodule

`default_nettype wire

// file: srst_monitor.sv
// Bus timing and reset-control checks for the soft reset block
`timescale 1ns/1ps
`default_nettype none
`include "srst_consts.svh"

module srst_monitor
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 reset,
    // Bus
    input wire srst_pkg::srst_addr_t s_axi_awaddr,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire srst_pkg::srst_word_t s_axi_wdata,
    input wire srst_pkg::srst_strb_t s_axi_wstrb,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire srst_pkg::srst_resp_t s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire srst_pkg::srst_word_t s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    // Capabilities and unit resets
    input wire srst_pkg::srst_word_t capability_mask_2,
    input wire srst_pkg::srst_word_t capability_mask_1,
    input wire logic                 field_bus_unit_reset,
    input wire logic                 two_wire_unit_reset,
    input wire logic                 async_serial_zero_reset
);
    logic wr_go;

    // Only same-cycle address and data are timed exactly
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_wr_resp_time: assert property (wr_go |->
        !s_axi_bvalid ##2 s_axi_bvalid)
        else $error("write answer late or early");
    a_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer not next cycle");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_rsvd_read_zero: assert property (s_axi_rvalid |->
        (s_axi_rdata & ~(`SRST_IMPL_0 | `SRST_IMPL_1)) == 32'h0)
        else $error("unassigned bit reads one");
    a_unmapped_err: assert property (wr_go
        && s_axi_awaddr[11:3] != 9'h008
        |-> ##2 s_axi_bresp == `SRST_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_field_bus_follow: assert property (wr_go
        && s_axi_awaddr[11:2] == 10'h010 && s_axi_wstrb[3]
        && capability_mask_1[24] |-> ##3
        field_bus_unit_reset == $past(s_axi_wdata[24], 3))
        else $error("field bus reset not following write");
    a_cap_blocks: assert property (wr_go
        && s_axi_awaddr[11:2] == 10'h011 && !capability_mask_2[0]
        |-> ##3 $stable(async_serial_zero_reset))
        else $error("absent unit bit changed");
    a_unit_after_wr: assert property ($changed(two_wire_unit_reset)
        |-> $past(s_axi_bvalid))
        else $error("unit reset moved without write");
    a_aw_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule

bind srst_top srst_monitor i_srst_monitor
(
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .capability_mask_2, .capability_mask_1, .field_bus_unit_reset,
    .two_wire_unit_reset, .async_serial_zero_reset
);

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the soft reset block
`timescale 1ns/1ps
`default_nettype none
`include "srst_consts.svh"

module tb_top;
    import srst_pkg::*;

    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] c1;
        logic [31:0] c2;
        logic [1:0]  r;
    } srst_row_t;

    logic        clk = 1'b0, reset = 1'b1;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, cap1 = 32'h0, cap2 = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, units, m0 = 32'h0, m1 = 32'h0, got;
    logic [1:0]  rr;
    int          err_count = 0, check_count = 0, cyc = 0;
    logic        fb, sc, lp, sv, c2r, c1r, c0r, g3, g2, g1, g0, tw, ss, a1, a0;

    localparam logic [31:0] ONES = 32'hffff_ffff;
    // Partial masks leave some units absent
    srst_row_t rows [8] = '{
        '{12'h040, ONES, 4'hf, ONES, ONES, 2'h0},
        '{12'h044, ONES, 4'hf, ONES, ONES, 2'h0},
        '{12'h040, 32'h0, 4'hf, ONES, ONES, 2'h0},
        '{12'h044, 32'h0, 4'h6, ONES, ONES, 2'h0},
        '{12'h040, ONES, 4'hf, 32'h0000_0040, ONES, 2'h0},
        '{12'h044, 32'h0, 4'hf, ONES, 32'h0500_0010, 2'h0},
        '{12'h048, ONES, 4'hf, ONES, ONES, 2'h2},
        '{12'h03c, ONES, 4'hf, ONES, ONES, 2'h2}};

    assign units = {17'h0, fb, sc, lp, sv, c2r, c1r, c0r, g3, g2, g1, g0,
        tw, ss, a1, a0};

    srst_top i_srst_top
    (
        .clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capability_mask_1(cap1),
        .capability_mask_2(cap2), .field_bus_unit_reset(fb),
        .sampling_converter_reset(sc), .low_power_unit_reset(lp),
        .supervisor_timer_reset(sv), .comparator_two_reset(c2r),
        .comparator_one_reset(c1r), .comparator_zero_reset(c0r),
        .gp_counter_three_reset(g3), .gp_counter_two_reset(g2),
        .gp_counter_one_reset(g1), .gp_counter_zero_reset(g0),
        .two_wire_unit_reset(tw), .sync_serial_unit_reset(ss),
        .async_serial_one_reset(a1), .async_serial_zero_reset(a0)
    );

    always #4 clk = ~clk;

    task automatic end_sim();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Handshakes are judged before the edge, so no race on ready
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input int dly);
        logic pa, pw, ha, hw, hb;
        logic [1:0] r;
        logic [31:0] en;
        int n;
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        awvalid <= (dly == 0);
        while (pa || pw)
        begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge clk);
            n++;
            awvalid <= (awvalid && !ha) || (n == dly);
            wvalid <= wvalid && !hw;
            pa = pa && !ha;
            pw = pw && !hw;
        end
        bready <= 1'b1;
        do
        begin
            @(negedge clk);
            hb = bvalid;
            r = bresp;
            @(posedge clk);
        end
        while (!hb);
        bready <= 1'b0;
        en = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (a[11:2] == 10'h010)
            m0 = (m0 & ~(en & cap1 & `SRST_IMPL_0)) | (d & en & cap1);
        if (a[11:2] == 10'h011)
            m1 = (m1 & ~(en & cap2 & `SRST_IMPL_1))
                | (d & en & cap2 & `SRST_IMPL_1);
        m0 = m0 & `SRST_IMPL_0;
        rr = r;
    endtask

    task automatic rd(input logic [11:0] a);
        logic h;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(negedge clk);
            h = arvalid && arready;
            @(posedge clk);
        end
        while (!h);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do
        begin
            @(negedge clk);
            h = rvalid;
            got = rdata;
            @(posedge clk);
        end
        while (!h);
        rready <= 1'b0;
    endtask

    function automatic logic [31:0] units_exp();
        return {17'h0, m0[24], m0[16], m0[6], m0[3], m1[26:24], m1[19:16],
            m1[12], m1[4], m1[1:0]};
    endfunction

    task automatic chk_regs();
        rd(12'h040);
        chk_w(got, m0);
        rd(12'h044);
        chk_w(got, m1);
        chk_w(units, units_exp());
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            end_sim();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk_w(units, 32'h0);
        foreach (rows[i])
        begin
            cap1 <= rows[i].c1;
            cap2 <= rows[i].c2;
            wr(rows[i].a, rows[i].d, rows[i].s, 0);
            chk_r(rr, rows[i].r);
            chk_regs();
        end
        rd(12'h048);
        chk_w(got, 32'h0);
        chk_r(rresp, `SRST_RESP_SLVERR);
        cap1 <= ONES;
        cap2 <= ONES;
        // Data offered three cycles ahead of its address
        wr(12'h040, 32'h0100_0008, 4'h9, 3);
        chk_regs();
        fork
            wr(12'h044, 32'h0000_1000, 4'h2, 0);
            rd(12'h040);
        join
        chk_w(got, m0);
        chk_regs();
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        chk_w(units, 32'h0);
        reset <= 1'b0;
        m0 = 32'h0;
        m1 = 32'h0;
        @(posedge clk);
        chk_regs();
        end_sim();
    end
endmodule

`default_nettype wire
